// *** src/dtc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtc_top (
  // Clock, reset and freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Gate and count pins
  input wire logic ext_gate_pin_zero,
  input wire logic ext_gate_pin_one,
  input wire logic timer_zero_count_pin,
  input wire logic timer_one_count_pin,
  // Interrupt vector acknowledges
  input wire logic timer_zero_vector_ack,
  input wire logic timer_one_vector_ack,
  // Flags and interrupt
  output logic timer_zero_overflow_flag,
  output logic timer_one_overflow_flag,
  output logic irq
);
  logic half_reg;
  logic [7:0] mode_reg;
  logic run0_reg;
  logic run1_reg;
  logic tf0_reg;
  logic tf0_next;
  logic tf1_reg;
  logic tf1_next;
  logic [1:0] stat_reg;
  logic [1:0] stat_next;
  logic [1:0] mask_reg;
  logic irq_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [dtc_pkg::NUM_PINS-1:0] pin_raw;
  logic [dtc_pkg::NUM_PINS-1:0] pin_lvl;
  logic [dtc_pkg::NUM_PINS-1:0] pin_fall;
  logic [9:0] widx;
  logic sel_ctrl;
  logic sel_mode;
  logic sel_t0_lo;
  logic sel_t1_lo;
  logic sel_t0_hi;
  logic sel_t1_hi;
  logic sel_stat;
  logic sel_mask;
  logic hit;
  logic setup;
  logic wr_acc;
  logic [7:0] ctrl_rd;
  logic [7:0] rd_byte;
  dtc_pkg::dtc_mode_t t0_mode;
  dtc_pkg::dtc_mode_t t1_mode;
  logic t0_split;
  logic tick;
  logic en0;
  logic en1;
  logic evt0;
  logic evt1;
  logic [1:0] ev;
  logic [1:0] t_inc_lo;
  logic [1:0] t_inc_hi;
  logic [1:0] t_wr_lo;
  logic [1:0] t_wr_hi;
  logic [1:0] t_ovf;
  logic [1:0] t_ovf_hi;
  dtc_pkg::dtc_mode_t t_mode [2];
  logic [7:0] t_lo [2];
  logic [7:0] t_hi [2];

  dtc_cnt_if tif [2] ();

  // Pin bank: three-stage synchronisers with edge detect
  assign pin_raw[dtc_pkg::PIN_TIMER_ZERO_GATE_SELECT] = ext_gate_pin_zero;
  assign pin_raw[dtc_pkg::PIN_TIMER_ONE_GATE_SELECT] = ext_gate_pin_one;
  assign pin_raw[dtc_pkg::PIN_CNT0] = timer_zero_count_pin;
  assign pin_raw[dtc_pkg::PIN_CNT1] = timer_one_count_pin;

  generate
    for (genvar p = 0; p < dtc_pkg::NUM_PINS; p++) begin : g_pin
      dtc_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .pin(pin_raw[p]),
        .level(pin_lvl[p]),
        .fall(pin_fall[p])
      );
    end
  endgenerate

  // Address decode on word index
  assign widx = paddr[11:2];
  assign sel_ctrl = widx == dtc_pkg::IDX_CTRL;
  assign sel_mode = widx == dtc_pkg::IDX_MODE;
  assign sel_t0_lo = widx == dtc_pkg::IDX_T0_LO;
  assign sel_t1_lo = widx == dtc_pkg::IDX_T1_LO;
  assign sel_t0_hi = widx == dtc_pkg::IDX_T0_HI;
  assign sel_t1_hi = widx == dtc_pkg::IDX_T1_HI;
  assign sel_stat = widx == dtc_pkg::IDX_IRQ_STAT;
  assign sel_mask = widx == dtc_pkg::IDX_IRQ_MASK;
  assign hit = |{sel_ctrl, sel_mode, sel_t0_lo, sel_t1_lo,
                 sel_t0_hi, sel_t1_hi, sel_stat, sel_mask};
  assign setup = psel & ~penable;
  // Writes land only on the completing access edge
  assign wr_acc = psel & penable & pready_reg & pwrite & hit;

  // Run and flag register image
  always_comb begin
    ctrl_rd = dtc_pkg::BYTE_RST;
    ctrl_rd[dtc_pkg::CTRL_TF1] = tf1_reg;
    ctrl_rd[dtc_pkg::CTRL_TR1] = run1_reg;
    ctrl_rd[dtc_pkg::CTRL_TF0] = tf0_reg;
    ctrl_rd[dtc_pkg::CTRL_TR0] = run0_reg;
  end

  // Read selection; unmapped words read as zero
  assign rd_byte = sel_ctrl ? ctrl_rd
                 : sel_mode ? mode_reg
                 : sel_t0_lo ? t_lo[0]
                 : sel_t1_lo ? t_lo[1]
                 : sel_t0_hi ? t_hi[0]
                 : sel_t1_hi ? t_hi[1]
                 : sel_stat ? {6'h00, stat_reg}
                 : sel_mask ? {6'h00, mask_reg}
                 : dtc_pkg::BYTE_RST;

  // Mode fields and count enables
  assign t0_mode = dtc_pkg::dtc_mode_t'(mode_reg[dtc_pkg::MODE_T0_LSB +: 2]);
  assign t1_mode = dtc_pkg::dtc_mode_t'(mode_reg[dtc_pkg::MODE_T1_LSB +: 2]);
  assign t0_split = t0_mode == dtc_pkg::DTC_MODE_SPLIT;
  assign tick = half_reg;
  assign en0 = run0_reg & (~mode_reg[dtc_pkg::MODE_TIMER_ZERO_GATE_SELECT]
                           | pin_lvl[dtc_pkg::PIN_TIMER_ZERO_GATE_SELECT]);
  assign en1 = run1_reg & (~mode_reg[dtc_pkg::MODE_TIMER_ONE_GATE_SELECT]
                           | pin_lvl[dtc_pkg::PIN_TIMER_ONE_GATE_SELECT]);
  assign evt0 = mode_reg[dtc_pkg::MODE_SRC0]
              ? pin_fall[dtc_pkg::PIN_CNT0] : tick;
  assign evt1 = mode_reg[dtc_pkg::MODE_SRC1]
              ? pin_fall[dtc_pkg::PIN_CNT1] : tick;

  // Per-timer control; the split high byte borrows timer one run
  assign t_mode[0] = t0_mode;
  assign t_mode[1] = t1_mode;
  assign t_inc_lo[0] = en0 & evt0;
  assign t_inc_hi[0] = t0_split & run1_reg & tick;
  assign t_inc_lo[1] = en1 & evt1
                     & (t1_mode != dtc_pkg::DTC_MODE_SPLIT);
  assign t_inc_hi[1] = 1'b0;
  assign t_wr_lo[0] = wr_acc & sel_t0_lo;
  assign t_wr_lo[1] = wr_acc & sel_t1_lo;
  assign t_wr_hi[0] = wr_acc & sel_t0_hi;
  assign t_wr_hi[1] = wr_acc & sel_t1_hi;

  generate
    for (genvar t = 0; t < 2; t++) begin : g_tmr
      assign tif[t].mode = t_mode[t];
      assign tif[t].inc_lo = t_inc_lo[t];
      assign tif[t].inc_hi = t_inc_hi[t];
      assign tif[t].wr_lo = t_wr_lo[t];
      assign tif[t].wr_hi = t_wr_hi[t];
      assign tif[t].wdata = pwdata[7:0];
      assign t_lo[t] = tif[t].lo;
      assign t_hi[t] = tif[t].hi;
      assign t_ovf[t] = tif[t].ovf;
      assign t_ovf_hi[t] = tif[t].ovf_hi;
      dtc_timer u_tmr (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .bus(tif[t])
      );
    end
  endgenerate

  // In split mode timer one loses its flag to the borrowed byte
  assign ev[dtc_pkg::IRQ_T0] = t_ovf[0];
  assign ev[dtc_pkg::IRQ_T1] = t0_split ? t_ovf_hi[0] : t_ovf[1];

  // Flags: hardware set beats vector clear beats software write
  assign tf0_next = ev[dtc_pkg::IRQ_T0] ? 1'b1
                  : timer_zero_vector_ack ? 1'b0
                  : (wr_acc & sel_ctrl) ? pwdata[dtc_pkg::CTRL_TF0]
                  : tf0_reg;
  assign tf1_next = ev[dtc_pkg::IRQ_T1] ? 1'b1
                  : timer_one_vector_ack ? 1'b0
                  : (wr_acc & sel_ctrl) ? pwdata[dtc_pkg::CTRL_TF1]
                  : tf1_reg;
  // Status bits are write-one-to-clear; a new event wins
  assign stat_next = ev | (stat_reg & ~((wr_acc & sel_stat)
                                        ? pwdata[1:0] : 2'h0));

  // Timer clock divider, runs free so tick rate never depends on run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_reg <= 1'b0;
    end else if (clk_en) begin
      half_reg <= ~half_reg;
    end
  end

  // Software-owned control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= dtc_pkg::BYTE_RST;
      run0_reg <= 1'b0;
      run1_reg <= 1'b0;
      mask_reg <= 2'h0;
    end else if (clk_en && wr_acc) begin
      if (sel_mode) begin
        mode_reg <= pwdata[7:0];
      end else if (sel_ctrl) begin
        run0_reg <= pwdata[dtc_pkg::CTRL_TR0];
        run1_reg <= pwdata[dtc_pkg::CTRL_TR1];
      end else if (sel_mask) begin
        mask_reg <= pwdata[1:0];
      end
    end
  end

  // Flags, status and interrupt line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tf0_reg <= 1'b0;
      tf1_reg <= 1'b0;
      stat_reg <= 2'h0;
      irq_reg <= 1'b0;
    end else if (clk_en) begin
      tf0_reg <= tf0_next;
      tf1_reg <= tf1_next;
      stat_reg <= stat_next;
      irq_reg <= |(stat_reg & mask_reg);
    end
  end

  // APB answer: ready rises one edge after setup, so no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= dtc_pkg::WORD_RST;
    end else if (clk_en) begin
      pready_reg <= setup;
      if (setup) begin
        pslverr_reg <= ~hit;
        prdata_reg <= {24'h000000, rd_byte};
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
  assign timer_zero_overflow_flag = tf0_reg;
  assign timer_one_overflow_flag = tf1_reg;

  // Checks on counting and flag behaviour
  logic quiet;
  logic [15:0] cnt0;
  logic [15:0] cnt1;
  logic t0_free;
  assign quiet = clk_en & ~wr_acc;
  assign cnt0 = {t_hi[0], t_lo[0]};
  assign cnt1 = {t_hi[1], t_lo[1]};
  assign t0_free = quiet & (t0_mode == dtc_pkg::DTC_MODE_WIDE) & run0_reg
                 & ~mode_reg[dtc_pkg::MODE_TIMER_ZERO_GATE_SELECT]
                 & ~mode_reg[dtc_pkg::MODE_SRC0];

  sequence s_t0_free_two;
    t0_free [*2];
  endsequence

  property p_t0_rate;
    @(posedge pclk) disable iff (!presetn)
      s_t0_free_two |=> cnt0 == 16'($past(cnt0, 2) + 16'h0001);
  endproperty
  a_t0_rate: assert property (p_t0_rate)
    else $error("timer zero did not advance once per two clocks");

  property p_t0_gate_hold;
    @(posedge pclk) disable iff (!presetn)
      (quiet && mode_reg[dtc_pkg::MODE_TIMER_ZERO_GATE_SELECT] && !t0_split
       && !pin_lvl[dtc_pkg::PIN_TIMER_ZERO_GATE_SELECT]) |=> $stable(cnt0);
  endproperty
  a_t0_gate_hold: assert property (p_t0_gate_hold)
    else $error("timer zero counted with its gate pin low");

  property p_t1_gate_hold;
    @(posedge pclk) disable iff (!presetn)
      (quiet && mode_reg[dtc_pkg::MODE_TIMER_ONE_GATE_SELECT]
       && !pin_lvl[dtc_pkg::PIN_TIMER_ONE_GATE_SELECT]) |=> $stable(cnt1);
  endproperty
  a_t1_gate_hold: assert property (p_t1_gate_hold)
    else $error("timer one counted with its gate pin low");

  property p_t1_pin_count;
    @(posedge pclk) disable iff (!presetn)
      (quiet && t1_mode == dtc_pkg::DTC_MODE_WIDE && en1
       && mode_reg[dtc_pkg::MODE_SRC1] && pin_fall[dtc_pkg::PIN_CNT1])
      |=> cnt1 == 16'($past(cnt1) + 16'h0001);
  endproperty
  a_t1_pin_count: assert property (p_t1_pin_count)
    else $error("timer one missed a count pin falling edge");

  property p_t1_stop;
    @(posedge pclk) disable iff (!presetn)
      (quiet && t1_mode == dtc_pkg::DTC_MODE_SPLIT) |=> $stable(cnt1);
  endproperty
  a_t1_stop: assert property (p_t1_stop)
    else $error("timer one counted in its stopped mode");

  property p_t0_reload;
    @(posedge pclk) disable iff (!presetn)
      (quiet && t0_mode == dtc_pkg::DTC_MODE_RELOAD && t_inc_lo[0]
       && t_lo[0] == dtc_pkg::BYTE_MAX)
      |=> (t_lo[0] == $past(t_hi[0])) && tf0_reg;
  endproperty
  a_t0_reload: assert property (p_t0_reload)
    else $error("timer zero low byte not reloaded on overflow");

  sequence s_split_wrap;
    quiet && t0_split && run1_reg && tick
      && t_hi[0] == dtc_pkg::BYTE_MAX;
  endsequence

  property p_split_flag;
    @(posedge pclk) disable iff (!presetn)
      s_split_wrap |=> tf1_reg && stat_reg[dtc_pkg::IRQ_T1]
                       && t_hi[0] == dtc_pkg::BYTE_RST;
  endproperty
  a_split_flag: assert property (p_split_flag)
    else $error("split high byte wrap did not raise timer one flag");

  property p_vector_clear;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && timer_zero_vector_ack && !ev[dtc_pkg::IRQ_T0])
      |=> !tf0_reg;
  endproperty
  a_vector_clear: assert property (p_vector_clear)
    else $error("vector acknowledge did not clear timer zero flag");

  property p_run_stop;
    @(posedge pclk) disable iff (!presetn)
      (!run0_reg && quiet && !t0_split) |=> $stable(cnt0);
  endproperty
  a_run_stop: assert property (p_run_stop)
    else $error("timer zero counted while its run bit was clear");
endmodule
`default_nettype wire

// *** src/dtc_pkg.sv ***
package dtc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h088;
  localparam logic [9:0] IDX_MODE = 10'h089;
  localparam logic [9:0] IDX_T0_LO = 10'h08A;
  localparam logic [9:0] IDX_T1_LO = 10'h08B;
  localparam logic [9:0] IDX_T0_HI = 10'h08C;
  localparam logic [9:0] IDX_T1_HI = 10'h08D;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h0A0;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h0A1;

  // Run and flag register bit positions
  localparam int CTRL_TF1 = 7;
  localparam int CTRL_TR1 = 6;
  localparam int CTRL_TF0 = 5;
  localparam int CTRL_TR0 = 4;

  // Mode control register bit positions
  localparam int MODE_TIMER_ONE_GATE_SELECT = 7;
  localparam int MODE_SRC1 = 6;
  localparam int MODE_T1_LSB = 4;
  localparam int MODE_TIMER_ZERO_GATE_SELECT = 3;
  localparam int MODE_SRC0 = 2;
  localparam int MODE_T0_LSB = 0;

  // Interrupt status and mask bit positions
  localparam int IRQ_T0 = 0;
  localparam int IRQ_T1 = 1;

  // Reset values and count limits
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [4:0] PRE_MAX = 5'h1F;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // Pin slots of the synchroniser bank
  localparam int NUM_PINS = 4;
  localparam int PIN_TIMER_ZERO_GATE_SELECT = 0;
  localparam int PIN_TIMER_ONE_GATE_SELECT = 1;
  localparam int PIN_CNT0 = 2;
  localparam int PIN_CNT1 = 3;

  // Counting modes
  typedef enum logic [1:0] {
    DTC_MODE_PRESCALE = 2'h0,
    DTC_MODE_WIDE = 2'h1,
    DTC_MODE_RELOAD = 2'h2,
    DTC_MODE_SPLIT = 2'h3
  } dtc_mode_t;

endpackage

// *** src/dtc_cnt_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface dtc_cnt_if;
  dtc_pkg::dtc_mode_t mode;
  logic inc_lo;
  logic inc_hi;
  logic wr_lo;
  logic wr_hi;
  logic [7:0] wdata;
  logic [7:0] lo;
  logic [7:0] hi;
  logic ovf;
  logic ovf_hi;

  // Control side drives counts and writes, counter side answers
  modport ctl (output mode, inc_lo, inc_hi, wr_lo, wr_hi, wdata,
               input lo, hi, ovf, ovf_hi);
  modport cnt (input mode, inc_lo, inc_hi, wr_lo, wr_hi, wdata,
               output lo, hi, ovf, ovf_hi);
endinterface
`default_nettype wire

// *** src/dtc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtc_sync (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Raw pin
  input wire logic pin,
  // Filtered level and its falling edge
  output logic level,
  output logic fall
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic level_reg;
  logic agree;

  // Level moves only when stages two and three agree
  assign agree = s2_reg == s3_reg;
  assign level = level_reg;
  assign fall = level_reg & agree & ~s3_reg;

  // Three-stage chain; stage one feeds only stage two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_reg <= 1'b0;
    end else if (clk_en) begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) begin
        level_reg <= s3_reg;
      end
    end
  end
endmodule
`default_nettype wire

// *** src/dtc_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module dtc_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Count and write control
  dtc_cnt_if.cnt bus
);
  logic [7:0] lo_reg;
  logic [7:0] lo_next;
  logic [7:0] hi_reg;
  logic [7:0] hi_next;
  logic lo_full;
  logic hi_full;
  logic pre_full;

  assign lo_full = lo_reg == dtc_pkg::BYTE_MAX;
  assign hi_full = hi_reg == dtc_pkg::BYTE_MAX;
  assign pre_full = lo_reg[4:0] == dtc_pkg::PRE_MAX;
  assign bus.lo = lo_reg;
  assign bus.hi = hi_reg;

  // Count per mode; a software write to a byte wins over counting
  always_comb begin
    lo_next = lo_reg;
    hi_next = hi_reg;
    bus.ovf = 1'b0;
    bus.ovf_hi = 1'b0;
    case (bus.mode)
      dtc_pkg::DTC_MODE_PRESCALE: begin
        if (bus.inc_lo) begin
          lo_next[4:0] = lo_reg[4:0] + 5'h01;
          if (pre_full) begin
            hi_next = hi_reg + 8'h01;
            bus.ovf = hi_full;
          end
        end
      end
      dtc_pkg::DTC_MODE_WIDE: begin
        if (bus.inc_lo) begin
          lo_next = lo_reg + 8'h01;
          if (lo_full) begin
            hi_next = hi_reg + 8'h01;
            bus.ovf = hi_full;
          end
        end
      end
      dtc_pkg::DTC_MODE_RELOAD: begin
        if (bus.inc_lo) begin
          lo_next = lo_full ? hi_reg : lo_reg + 8'h01;
          bus.ovf = lo_full;
        end
      end
      default: begin
        if (bus.inc_lo) begin
          lo_next = lo_reg + 8'h01;
          bus.ovf = lo_full;
        end
        if (bus.inc_hi) begin
          hi_next = hi_reg + 8'h01;
          bus.ovf_hi = hi_full;
        end
      end
    endcase
    if (bus.wr_lo) begin
      lo_next = bus.wdata;
    end
    if (bus.wr_hi) begin
      hi_next = bus.wdata;
    end
  end

  // Count bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lo_reg <= dtc_pkg::BYTE_RST;
      hi_reg <= dtc_pkg::BYTE_RST;
    end else if (clk_en) begin
      lo_reg <= lo_next;
      hi_reg <= hi_next;
    end
  end

  // Prescaler wrap carries into the high byte, upper low bits idle
  property p_prescale_carry;
    @(posedge pclk) disable iff (!presetn)
      (clk_en && bus.mode == dtc_pkg::DTC_MODE_PRESCALE && bus.inc_lo
       && pre_full && !bus.wr_lo && !bus.wr_hi)
      |=> (hi_reg == 8'($past(hi_reg) + 8'h01))
          && (lo_reg[7:5] == $past(lo_reg[7:5]))
          && (lo_reg[4:0] == 5'h00);
  endproperty
  a_prescale_carry: assert property (p_prescale_carry)
    else $error("prescaler wrap did not carry into high byte");
endmodule
`default_nettype wire

// *** dv/dtc_pin_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Far side: gate pins follow requests, count pins make falling bursts
module dtc_pin_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests from the bench
  input wire logic [1:0] gate_req,
  input wire logic [1:0] burst_req,
  // Pins towards the timers
  output logic timer_zero_gate_select,
  output logic timer_one_gate_select,
  output logic cnt0,
  output logic cnt1
);
  logic [2:0] ph0;
  logic [2:0] ph1;

  // Phase counters; a fall every 8 cycles keeps each level 4 cycles wide
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph0 <= 3'h0;
      ph1 <= 3'h0;
    end else begin
      ph0 <= burst_req[0] ? ph0 + 3'h1 : 3'h0;
      ph1 <= burst_req[1] ? ph1 + 3'h1 : 3'h0;
    end
  end

  // Count pins rest high outside bursts, as with a pull-up
  assign cnt0 = burst_req[0] ? ph0[2] : 1'b1;
  assign cnt1 = burst_req[1] ? ph1[2] : 1'b1;
  assign timer_zero_gate_select = gate_req[0];
  assign timer_one_gate_select = gate_req[1];
endmodule
`default_nettype wire

// *** dv/dual_timer_counter_pair_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_pair_bench;
  // Byte addresses of the registers
  localparam logic [11:0] A_CTRL = {dtc_pkg::IDX_CTRL, 2'b00};
  localparam logic [11:0] A_MODE = {dtc_pkg::IDX_MODE, 2'b00};
  localparam logic [11:0] A_T0L = {dtc_pkg::IDX_T0_LO, 2'b00};
  localparam logic [11:0] A_T1L = {dtc_pkg::IDX_T1_LO, 2'b00};
  localparam logic [11:0] A_T0H = {dtc_pkg::IDX_T0_HI, 2'b00};
  localparam logic [11:0] A_T1H = {dtc_pkg::IDX_T1_HI, 2'b00};
  localparam logic [11:0] A_STAT = {dtc_pkg::IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_MASK = {dtc_pkg::IDX_IRQ_MASK, 2'b00};
  localparam logic [11:0] A_BAD = 12'h3FC;
  // Bus and pins
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] gate_req = 2'h0;
  logic [1:0] burst_req = 2'h0;
  logic g0, g1, c0, c1;
  logic ack0 = 1'b0;
  logic ack1 = 1'b0;
  logic clk_en = 1'b1;
  logic tf0, tf1, irq;
  // Bookkeeping
  int failures = 0;
  int comparisons = 0;
  logic [31:0] rd;
  logic rerr;
  logic [11:0] regs [0:5];

  dtc_top dtc_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_gate_pin_zero(g0), .ext_gate_pin_one(g1),
    .timer_zero_count_pin(c0), .timer_one_count_pin(c1),
    .timer_zero_vector_ack(ack0), .timer_one_vector_ack(ack1),
    .timer_zero_overflow_flag(tf0), .timer_one_overflow_flag(tf1),
    .irq(irq));
  dtc_pin_model dtc_pin_model_inst (.pclk(pclk), .presetn(presetn),
    .gate_req(gate_req), .burst_req(burst_req), .timer_zero_gate_select(g0), .timer_one_gate_select(g1),
    .cnt0(c0), .cnt1(c1));

  // Free-running 25 MHz clock
  initial begin
    forever #20 pclk = ~pclk;
  end

  task automatic tally_and_finish;
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait for ready
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, {24'h0, exp});
  endtask

  // Load, run for 40 edges or a pin burst, stop, read back
  task automatic run(input logic [7:0] mode, input logic [7:0] on,
    input int t, input logic [7:0] lo, input logic [7:0] hi,
    input logic [7:0] elo, input logic [7:0] ehi, input logic [1:0] ef,
    input int pulses);
    wr(A_MODE, mode);
    wr(t ? A_T1L : A_T0L, lo);
    wr(t ? A_T1H : A_T0H, hi);
    wr(A_CTRL, on);
    if (pulses == 0) begin
      repeat (37) @(posedge pclk);
    end else begin
      burst_req[t] <= 1'b1;
      repeat (8 * pulses) @(posedge pclk);
      burst_req[t] <= 1'b0;
      repeat (8) @(posedge pclk);
    end
    check({30'h0, tf1, tf0}, {30'h0, ef});
    wr(A_CTRL, 8'h00);
    rdchk(t ? A_T1L : A_T0L, elo);
    rdchk(t ? A_T1H : A_T0H, ehi);
  endtask

  // Watchdog well beyond the roughly one thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end

  initial begin
    regs = '{A_CTRL, A_MODE, A_T0L, A_T1L, A_T0H, A_T1H};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) rdchk(regs[i], 8'h00);
    wr(A_T1H, 8'hA5);
    rdchk(A_T1H, 8'hA5);
    wr(A_BAD, 8'hFF);
    check({31'h0, rerr}, 32'h1);
    $display("test registers done");
    // Wide mode overflow, then the interrupt path
    run(8'h01, 8'h10, 0, 8'hF0, 8'hFF, 8'h04, 8'h00, 2'b01, 0);
    check({31'h0, irq}, 32'h0);
    wr(A_MASK, 8'h01);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    wr(A_STAT, 8'h01);
    repeat (2) @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    rdchk(A_STAT, 8'h00);
    $display("test overflow done");
    // Prescale, reload and wide modes at two clocks per count
    run(8'h00, 8'h40, 1, 8'hFE, 8'h00, 8'hF2, 8'h01, 2'b00, 0);
    run(8'h00, 8'h10, 0, 8'h3F, 8'h07, 8'h33, 8'h08, 2'b00, 0);
    run(8'h02, 8'h10, 0, 8'hFC, 8'hE0, 8'hF0, 8'hE0, 2'b01, 0);
    run(8'h20, 8'h40, 1, 8'hFC, 8'hE0, 8'hF0, 8'hE0, 2'b10, 0);
    run(8'h10, 8'h40, 1, 8'hF0, 8'h12, 8'h04, 8'h13, 2'b00, 0);
    $display("test modes done");
    // Gate pin low blocks counting, high lets it through
    for (int g = 0; g < 2; g++) begin
      gate_req <= {g[0], g[0]};
      repeat (8) @(posedge pclk);
      run(8'h09, 8'h10, 0, 8'h00, 8'h00, g ? 8'h14 : 8'h00, 8'h00,
          2'b00, 0);
      run(8'h90, 8'h40, 1, 8'h00, 8'h00, g ? 8'h14 : 8'h00, 8'h00,
          2'b00, 0);
    end
    gate_req <= 2'h0;
    $display("test gate done");
    // Counter mode counts pin falls, not clocks
    run(8'h05, 8'h10, 0, 8'h00, 8'h00, 8'h05, 8'h00, 2'b00, 5);
    run(8'h50, 8'h40, 1, 8'h00, 8'h00, 8'h05, 8'h00, 2'b00, 5);
    $display("test counter done");
    // Timer one halted; split timer zero
    run(8'h30, 8'h40, 1, 8'h55, 8'h66, 8'h55, 8'h66, 2'b00, 0);
    run(8'h03, 8'h10, 0, 8'h10, 8'h20, 8'h24, 8'h20, 2'b00, 0);
    run(8'h03, 8'h40, 0, 8'h10, 8'hF0, 8'h10, 8'h04, 2'b10, 0);
    $display("test split done");
    // Vector acknowledges clear their own flag only
    wr(A_CTRL, 8'hA0);
    // Flags settle only after the write edge has passed
    @(posedge pclk);
    check({30'h0, tf1, tf0}, 32'h3);
    @(posedge pclk);
    ack0 <= 1'b1;
    @(posedge pclk);
    ack0 <= 1'b0;
    @(posedge pclk);
    check({30'h0, tf1, tf0}, 32'h2);
    ack1 <= 1'b1;
    @(posedge pclk);
    ack1 <= 1'b0;
    @(posedge pclk);
    check({30'h0, tf1, tf0}, 32'h0);
    $display("test vector done");
    // Clock enable low freezes the count and the tick divider
    wr(A_MODE, 8'h01);
    wr(A_T0L, 8'h00);
    wr(A_T0H, 8'h00);
    wr(A_CTRL, 8'h10);
    clk_en <= 1'b0;
    repeat (30) @(posedge pclk);
    clk_en <= 1'b1;
    @(posedge pclk);
    wr(A_CTRL, 8'h00);
    rdchk(A_T0L, 8'h02);
    rdchk(A_T0H, 8'h00);
    $display("test freeze done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
